//--- pkg/spbr_pkg.sv
// Shared constants, encodings and state types for the serial port block
package spbr_pkg;

  // ***************************************************************
  // Line timing, default 38400 8N1 on a 10 MHz clock
  // ***************************************************************
  localparam int          CLK_HZ     = 10_000_000;
  localparam int          BAUD_BPS   = 38_400;
  localparam int          BAUD_DIV   = CLK_HZ / BAUD_BPS;
  localparam logic [15:0] BAUD_LAST  = 16'(BAUD_DIV - 1);
  localparam logic [15:0] BAUD_HALF  = 16'(BAUD_DIV / 2 - 1);
  localparam logic [3:0]  FRAME_BITS = 4'ha;
  localparam logic [3:0]  STOP_BIT   = 4'h9;
  localparam logic [9:0]  LINE_IDLE  = 10'h3ff;

  // ***************************************************************
  // Buffers and characters
  // ***************************************************************
  localparam int          BUF_DEPTH  = 256;
  localparam logic [8:0]  BUF_FULL   = 9'h100;
  localparam logic [7:0]  TERM_CHAR  = 8'h0d;
  localparam logic [8:0]  NO_CHAR    = 9'h1ff;

  // ***************************************************************
  // Timeouts
  // ***************************************************************
  localparam int          TICK_MS     = 10;
  localparam int          TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int          QRY_MS      = 150;
  localparam int          QRY_CYCLES  = CLK_HZ / 1000 * QRY_MS;
  localparam logic [1:0]  QRY_TRIES   = 2'h3;
  localparam int          AUTO_IDLE_S = 10;
  localparam int          AUTO_CYCLES = CLK_HZ * AUTO_IDLE_S;

  // ***************************************************************
  // Slave address map: group base (exclusive) and size
  // ***************************************************************
  localparam logic [15:0] BIT_IN_BASE  = 16'h0000;
  localparam logic [15:0] BIT_OUT_BASE = 16'h0100;
  localparam logic [15:0] BIT_IO_CNT   = 16'h0060;
  localparam logic [15:0] BIT_TMR_BASE = 16'h0200;
  localparam logic [15:0] BIT_CNT_BASE = 16'h0300;
  localparam logic [15:0] BIT_TC_CNT   = 16'h0040;
  localparam logic [15:0] BIT_RLY_BASE = 16'h0400;
  localparam logic [15:0] BIT_RLY_CNT  = 16'h0200;
  localparam logic [15:0] W_IN_BASE    = 16'h0000;
  localparam logic [15:0] W_OUT_BASE   = 16'h0010;
  localparam logic [15:0] W_IO_CNT     = 16'h0006;
  localparam logic [15:0] W_TMR_BASE   = 16'h0020;
  localparam logic [15:0] W_CNT_BASE   = 16'h0030;
  localparam logic [15:0] W_TC_CNT     = 16'h0004;
  localparam logic [15:0] W_RLY_BASE   = 16'h0040;
  localparam logic [15:0] W_RLY_CNT    = 16'h0020;
  localparam logic [15:0] W_TPV_BASE   = 16'h0080;
  localparam logic [15:0] W_CPV_BASE   = 16'h0100;
  localparam logic [15:0] W_PV_CNT     = 16'h0040;
  localparam logic [15:0] W_CLK_BASE   = 16'h0200;
  localparam logic [15:0] W_CLK_CNT    = 16'h0003;
  localparam logic [15:0] W_DATE_BASE  = 16'h0204;
  localparam logic [15:0] W_DATE_CNT   = 16'h0004;
  localparam logic [15:0] W_MEM_BASE   = 16'h03e8;
  localparam logic [15:0] W_MEM_CNT    = 16'h0fa0;

  typedef enum logic [3:0] {
    MAP_NONE = 4'h0, MAP_IN  = 4'h1, MAP_OUT  = 4'h2, MAP_TMR = 4'h3,
    MAP_CNT  = 4'h4, MAP_RLY = 4'h5, MAP_TPV  = 4'h6, MAP_CPV = 4'h7,
    MAP_CLK  = 4'h8, MAP_DATE = 4'h9, MAP_MEM = 4'ha
  } spbr_map_t;

  typedef enum logic [2:0] {
    MODE_AUTO  = 3'h0, MODE_NATIVE = 3'h1, MODE_ASCII  = 3'h2,
    MODE_RTU   = 3'h3, MODE_LEGACY = 3'h4, MODE_NOPROT = 3'h5
  } spbr_mode_t;

  typedef enum logic [1:0] {
    LN_IDLE = 2'h0, LN_SCAN = 2'h1, LN_WAIT = 2'h2, LN_POP = 2'h3
  } spbr_line_t;

  typedef enum logic [1:0] {
    QR_IDLE = 2'h0, QR_SEND = 2'h1, QR_WAIT = 2'h2
  } spbr_qry_t;

endpackage : spbr_pkg

//--- hdl/spbr_uart.sv
// Fixed-format 8N1 serial receiver and transmitter
`timescale 1ns/1ps

module spbr_uart (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       rxPin,
  output logic            txPin,
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       txStart,
  input  wire logic [7:0] txData,
  output logic            txBusy
);
  import spbr_pkg::*;

  logic        rxS1_q;
  logic        rxS2_q;
  logic        rxAct_q;
  logic [15:0] rxCnt_q;
  logic [3:0]  rxBit_q;
  logic [7:0]  rxSh_q;
  logic [15:0] txCnt_q;
  logic [3:0]  txBit_q;
  logic [9:0]  txSh_q;

  // ***************************************************************
  // Receiver: pin synchroniser, mid-bit sampling
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rxS1_q <= 1'b1;
      rxS2_q <= 1'b1;
    end else begin
      rxS1_q <= rxPin;
      rxS2_q <= rxS1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rxAct_q <= 1'b0;
      rxCnt_q <= 16'h0000;
      rxBit_q <= 4'h0;
      rxSh_q  <= 8'h00;
      rxValid <= 1'b0;
      rxData  <= 8'h00;
    end else begin
      rxValid <= 1'b0;
      if (!rxAct_q) begin
        if (!rxS2_q) begin
          rxAct_q <= 1'b1;
          rxCnt_q <= BAUD_HALF;
          rxBit_q <= 4'h0;
        end
      end else if (rxCnt_q != 16'h0000) begin
        rxCnt_q <= rxCnt_q - 16'h0001;
      end else begin
        rxCnt_q <= BAUD_LAST;
        rxBit_q <= rxBit_q + 4'h1;
        if (rxBit_q == 4'h0 && rxS2_q) begin
          rxAct_q <= 1'b0;
        end else if (rxBit_q == STOP_BIT) begin
          // Framing errors are dropped silently
          rxAct_q <= 1'b0;
          rxValid <= rxS2_q;
          rxData  <= rxSh_q;
        end else if (rxBit_q != 4'h0) begin
          rxSh_q <= {rxS2_q, rxSh_q[7:1]};
        end
      end
    end
  end

  // ***************************************************************
  // Transmitter: busy until the end of the stop bit
  // ***************************************************************
  assign txBusy = txBit_q != 4'h0;
  assign txPin  = txSh_q[0];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txCnt_q <= 16'h0000;
      txBit_q <= 4'h0;
      txSh_q  <= LINE_IDLE;
    end else if (txStart && !txBusy) begin
      txSh_q  <= {1'b1, txData, 1'b0};
      txBit_q <= FRAME_BITS;
      txCnt_q <= BAUD_LAST;
    end else if (txBusy) begin
      if (txCnt_q != 16'h0000) begin
        txCnt_q <= txCnt_q - 16'h0001;
      end else begin
        txCnt_q <= BAUD_LAST;
        txBit_q <= txBit_q - 4'h1;
        txSh_q  <= {1'b1, txSh_q[9:1]};
      end
    end
  end

endmodule : spbr_uart

//--- hdl/spbr_top.sv
// Serial port buffering, line reads, transmit and RS485 direction control
`timescale 1ns/1ps

// How it works
// - Every received byte is stored in a 256-byte ring until read.
// - Protocol command bytes stay stored; protocol handling never removes them.
// - Past 256 unread bytes the oldest is overwritten; reception never stalls.
// - Single-character read pops one byte, or returns -1 when empty.
// - Line read finds byte 13 and removes the whole terminated string.
// - No terminator: buffer untouched, empty result at once when non-blocking.
// - Nonzero timeout t makes line reads wait up to t times 10 ms.
// - Timeout setting persists until rewritten; zero restores non-blocking.
// - Buffered send uses a separate 256-byte ring, in order, sparing rx.
// - Driver on while sending; off right after last stop bit.
// - Single-byte send bypasses the ring; driver spans just that byte.
// - Query sends, ends on reply or 0.15 s, retries on silence.
// - One 8-bit device identifier serves every slave protocol.
// - Bit addresses use one fixed map for functions 01, 02, 05.
// - Data words 1 to 4000 and I/O groups map to holding registers.
// - 32-bit and string variables have no slave address.
// - Locked protocol mode, except no-protocol, returns to automatic after 10 s idle.
// - Port starts at 38400 bit/s, 8 data, no parity, 1 stop.
module spbr_top #(
  parameter int TICK_CYC = spbr_pkg::TICK_CYCLES,
  parameter int QRY_CYC  = spbr_pkg::QRY_CYCLES,
  parameter int AUTO_CYC = spbr_pkg::AUTO_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                rxPin,
  output logic                     txPin,
  output logic                     rs485DriverEn,
  output logic                     rs485RecvEnN,
  input  wire logic                charRdReq,
  output logic                     charRdReady,
  output logic                     charRdValid,
  output logic [8:0]               charRdData,
  input  wire logic                lineRdReq,
  output logic                     lineRdReady,
  output logic                     lineByteValid,
  output logic [7:0]               lineByteData,
  output logic                     lineRdDone,
  output logic [8:0]               lineRdLen,
  input  wire logic                cfgTimeoutWe,
  input  wire logic [7:0]          cfgTimeoutData,
  output logic [7:0]               lineTimeout,
  output logic [8:0]               rxCount,
  input  wire logic                txWrValid,
  input  wire logic [7:0]          txWrData,
  output logic                     txWrReady,
  output logic [8:0]               txCount,
  input  wire logic                sendByteReq,
  input  wire logic [7:0]          sendByteData,
  output logic                     sendByteReady,
  input  wire logic                qryReq,
  output logic                     qryReady,
  output logic                     qryDone,
  output logic                     qryGotReply,
  input  wire logic                protoCmdSeen,
  input  wire logic                protoLockReq,
  input  wire spbr_pkg::spbr_mode_t protoLockMode,
  output spbr_pkg::spbr_mode_t     protoMode,
  input  wire logic [7:0]          deviceId,
  input  wire logic [7:0]          frameId,
  output logic                     frameIdHit,
  input  wire logic [15:0]         mapBitAddr,
  output spbr_pkg::spbr_map_t      mapBitKind,
  output logic [9:0]               mapBitIdx,
  input  wire logic [15:0]         mapWordAddr,
  output spbr_pkg::spbr_map_t      mapWordKind,
  output logic [11:0]              mapWordIdx
);
  import spbr_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
  localparam logic [20:0] QRY_LAST  = 21'(QRY_CYC - 1);
  localparam logic [26:0] AUTO_LAST = 27'(AUTO_CYC - 1);

  logic        rxValid;
  logic [7:0]  rxData;
  logic        uBusy;
  logic        uStart;
  logic [7:0]  uData;
  logic [7:0]  rxMem [BUF_DEPTH];
  logic [7:0]  rxWp_q;
  logic [7:0]  rxRp_q;
  logic [8:0]  rxCnt_q;
  spbr_line_t  lnSt_q;
  logic [8:0]  scanOff_q;
  logic [8:0]  popLeft_q;
  logic        blk_q;
  logic [16:0] tick_q;
  logic [7:0]  tLeft_q;
  logic [7:0]  timeout_q;
  logic [7:0]  txMem [BUF_DEPTH];
  logic [7:0]  txWp_q;
  logic [7:0]  txRp_q;
  logic [8:0]  txCnt_q;
  spbr_qry_t   qSt_q;
  logic [7:0]  qBase_q;
  logic [7:0]  msgBase_q;
  logic [8:0]  qLen_q;
  logic [1:0]  qTry_q;
  logic [20:0] qTmr_q;
  logic [26:0] autoCnt_q;

  // Fixed 8N1 at the default rate from reset onward
  spbr_uart uUart (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .rxPin   (rxPin),
    .txPin   (txPin),
    .rxValid (rxValid),
    .rxData  (rxData),
    .txStart (uStart),
    .txData  (uData),
    .txBusy  (uBusy)
  );

  // ***************************************************************
  // Receive ring
  // ***************************************************************
  wire       lineIdle = lnSt_q == LN_IDLE;
  wire       rxEmpty  = rxCnt_q == 9'h000;
  wire       rxFull   = rxCnt_q == BUF_FULL;
  wire       charTake = charRdReq && lineIdle;
  wire       rxPop    = (charTake || lnSt_q == LN_POP) && !rxEmpty;
  wire       rxDrop   = rxValid && rxFull && !rxPop;
  wire [7:0] scanPtr  = rxRp_q + scanOff_q[7:0];
  wire [7:0] scanByte = rxMem[scanPtr];
  wire       scanEnd  = scanOff_q == rxCnt_q;
  wire       scanHit  = !scanEnd && scanByte == TERM_CHAR;
  wire       tmrDone  = tick_q == 17'h00000 && tLeft_q == 8'h00;

  assign charRdReady = lineIdle;
  assign lineRdReady = lineIdle;
  assign rxCount     = rxCnt_q;
  assign lineTimeout = timeout_q;

  // All bytes land here, protocol frames included
  always_ff @(posedge ref_clk) begin
    if (rxValid) rxMem[rxWp_q] <= rxData;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rxWp_q  <= 8'h00;
      rxRp_q  <= 8'h00;
      rxCnt_q <= 9'h000;
    end else begin
      if (rxValid) rxWp_q <= rxWp_q + 8'h01;
      if (rxPop || rxDrop) rxRp_q <= rxRp_q + 8'h01;
      if (rxValid && !rxFull && !rxPop) rxCnt_q <= rxCnt_q + 9'h001;
      else if (!rxValid && rxPop) rxCnt_q <= rxCnt_q - 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      charRdValid <= 1'b0;
      charRdData  <= NO_CHAR;
    end else begin
      charRdValid <= charTake;
      if (charTake) charRdData <= rxEmpty ? NO_CHAR : {1'b0, rxMem[rxRp_q]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) timeout_q <= 8'h00;
    else if (cfgTimeoutWe) timeout_q <= cfgTimeoutData;
  end

  // ***************************************************************
  // Line read: scan without consuming, then pop the string
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lnSt_q        <= LN_IDLE;
      scanOff_q     <= 9'h000;
      popLeft_q     <= 9'h000;
      blk_q         <= 1'b0;
      tick_q        <= 17'h00000;
      tLeft_q       <= 8'h00;
      lineByteValid <= 1'b0;
      lineByteData  <= 8'h00;
      lineRdDone    <= 1'b0;
      lineRdLen     <= 9'h000;
    end else begin
      lineByteValid <= 1'b0;
      lineRdDone    <= 1'b0;
      if (!lineIdle && !tmrDone) begin
        if (tick_q != 17'h00000) begin
          tick_q <= tick_q - 17'h00001;
        end else begin
          tick_q  <= TICK_LAST;
          tLeft_q <= tLeft_q - 8'h01;
        end
      end
      case (lnSt_q)
        LN_IDLE: begin
          if (lineRdReq) begin
            lnSt_q    <= LN_SCAN;
            scanOff_q <= 9'h000;
            blk_q     <= timeout_q != 8'h00;
            tLeft_q   <= timeout_q - 8'h01;
            tick_q    <= TICK_LAST;
          end
        end
        LN_SCAN: begin
          if (scanHit) begin
            lnSt_q    <= LN_POP;
            popLeft_q <= scanOff_q;
            lineRdLen <= scanOff_q;
          end else if (scanEnd) begin
            if (blk_q && !tmrDone) begin
              lnSt_q <= LN_WAIT;
            end else begin
              lnSt_q     <= LN_IDLE;
              lineRdDone <= 1'b1;
              lineRdLen  <= 9'h000;
            end
          end else begin
            scanOff_q <= scanOff_q + 9'h001;
          end
        end
        LN_WAIT: begin
          if (rxValid && rxData == TERM_CHAR) begin
            lnSt_q    <= LN_SCAN;
            scanOff_q <= 9'h000;
          end else if (tmrDone) begin
            lnSt_q     <= LN_IDLE;
            lineRdDone <= 1'b1;
            lineRdLen  <= 9'h000;
          end
        end
        LN_POP: begin
          lineByteData <= rxMem[rxRp_q];
          if (popLeft_q == 9'h000) begin
            lnSt_q     <= LN_IDLE;
            lineRdDone <= 1'b1;
          end else begin
            lineByteValid <= 1'b1;
            popLeft_q     <= popLeft_q - 9'h001;
          end
        end
        default: lnSt_q <= LN_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Transmit ring, single-byte bypass and RS485 direction
  // ***************************************************************
  wire qIdle   = qSt_q == QR_IDLE;
  wire txEmpty = txCnt_q == 9'h000;
  wire txPush  = txWrValid && txWrReady;
  wire feedBuf = !uBusy && !txEmpty;
  wire single  = sendByteReq && sendByteReady;
  wire qExpire = qSt_q == QR_WAIT && qTmr_q == 21'h000000 && !rxValid;
  wire qRetry  = qExpire && qTry_q != QRY_TRIES - 2'h1;

  assign txWrReady     = txCnt_q != BUF_FULL && qIdle;
  assign sendByteReady = !uBusy && txEmpty && qIdle;
  assign uStart        = feedBuf || single;
  assign uData         = feedBuf ? txMem[txRp_q] : sendByteData;
  assign rs485DriverEn = uBusy || !txEmpty;
  assign rs485RecvEnN  = rs485DriverEn;
  assign txCount       = txCnt_q;
  assign qryReady      = qIdle;

  always_ff @(posedge ref_clk) begin
    if (txPush) txMem[txWp_q] <= txWrData;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      txWp_q  <= 8'h00;
      txRp_q  <= 8'h00;
      txCnt_q <= 9'h000;
      msgBase_q <= 8'h00;
    end else begin
      if (txPush) txWp_q <= txWp_q + 8'h01;
      // A message starts with the first byte put into an empty ring
      if (txPush && txEmpty) msgBase_q <= txWp_q;
      if (qRetry) begin
        txRp_q  <= qBase_q;
        txCnt_q <= qLen_q;
      end else begin
        if (feedBuf) txRp_q <= txRp_q + 8'h01;
        if (txPush && !feedBuf) txCnt_q <= txCnt_q + 9'h001;
        else if (!txPush && feedBuf) txCnt_q <= txCnt_q - 9'h001;
      end
    end
  end

  // ***************************************************************
  // Query with reply
  // ***************************************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      qSt_q       <= QR_IDLE;
      qBase_q     <= 8'h00;
      qLen_q      <= 9'h000;
      qTry_q      <= 2'h0;
      qTmr_q      <= 21'h000000;
      qryDone     <= 1'b0;
      qryGotReply <= 1'b0;
    end else begin
      qryDone <= 1'b0;
      case (qSt_q)
        QR_IDLE: begin
          if (qryReq) begin
            qSt_q       <= QR_SEND;
            qBase_q     <= msgBase_q;
            qLen_q      <= {1'b0, txWp_q - msgBase_q};
            qTry_q      <= 2'h0;
            qryGotReply <= 1'b0;
          end
        end
        QR_SEND: begin
          if (txEmpty && !uBusy) begin
            qSt_q  <= QR_WAIT;
            qTmr_q <= QRY_LAST;
          end
        end
        QR_WAIT: begin
          if (rxValid) begin
            qSt_q       <= QR_IDLE;
            qryDone     <= 1'b1;
            qryGotReply <= 1'b1;
          end else if (qRetry) begin
            qSt_q  <= QR_SEND;
            qTry_q <= qTry_q + 2'h1;
          end else if (qExpire) begin
            qSt_q   <= QR_IDLE;
            qryDone <= 1'b1;
          end else begin
            qTmr_q <= qTmr_q - 21'h000001;
          end
        end
        default: qSt_q <= QR_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Protocol mode self-reset
  // ***************************************************************
  wire modeTimed = protoMode != MODE_AUTO && protoMode != MODE_NOPROT;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      protoMode <= MODE_AUTO;
      autoCnt_q <= 27'h0000000;
    end else if (protoLockReq) begin
      protoMode <= protoLockMode;
      autoCnt_q <= AUTO_LAST;
    end else if (protoCmdSeen) begin
      autoCnt_q <= AUTO_LAST;
    end else if (modeTimed) begin
      if (autoCnt_q == 27'h0000000) protoMode <= MODE_AUTO;
      else autoCnt_q <= autoCnt_q - 27'h0000001;
    end
  end

  // ***************************************************************
  // Slave address decode
  // ***************************************************************
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic [15:0] n);
    return a > b && a <= b + n;
  endfunction : in_rng

  function automatic logic [13:0] map_bit(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (in_rng(a, BIT_IN_BASE, BIT_IO_CNT)) r = {MAP_IN, a[11:0] - BIT_IN_BASE[11:0]};
    else if (in_rng(a, BIT_OUT_BASE, BIT_IO_CNT)) r = {MAP_OUT, a[11:0] - BIT_OUT_BASE[11:0]};
    else if (in_rng(a, BIT_TMR_BASE, BIT_TC_CNT)) r = {MAP_TMR, a[11:0] - BIT_TMR_BASE[11:0]};
    else if (in_rng(a, BIT_CNT_BASE, BIT_TC_CNT)) r = {MAP_CNT, a[11:0] - BIT_CNT_BASE[11:0]};
    else if (in_rng(a, BIT_RLY_BASE, BIT_RLY_CNT)) r = {MAP_RLY, a[11:0] - BIT_RLY_BASE[11:0]};
    return {r[15:12], r[9:0]};
  endfunction : map_bit

  function automatic logic [15:0] map_word(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (in_rng(a, W_IN_BASE, W_IO_CNT)) r = {MAP_IN, a[11:0] - W_IN_BASE[11:0]};
    else if (in_rng(a, W_OUT_BASE, W_IO_CNT)) r = {MAP_OUT, a[11:0] - W_OUT_BASE[11:0]};
    else if (in_rng(a, W_TMR_BASE, W_TC_CNT)) r = {MAP_TMR, a[11:0] - W_TMR_BASE[11:0]};
    else if (in_rng(a, W_CNT_BASE, W_TC_CNT)) r = {MAP_CNT, a[11:0] - W_CNT_BASE[11:0]};
    else if (in_rng(a, W_RLY_BASE, W_RLY_CNT)) r = {MAP_RLY, a[11:0] - W_RLY_BASE[11:0]};
    else if (in_rng(a, W_TPV_BASE, W_PV_CNT)) r = {MAP_TPV, a[11:0] - W_TPV_BASE[11:0]};
    else if (in_rng(a, W_CPV_BASE, W_PV_CNT)) r = {MAP_CPV, a[11:0] - W_CPV_BASE[11:0]};
    else if (in_rng(a, W_CLK_BASE, W_CLK_CNT)) r = {MAP_CLK, a[11:0] - W_CLK_BASE[11:0]};
    else if (in_rng(a, W_DATE_BASE, W_DATE_CNT)) r = {MAP_DATE, a[11:0] - W_DATE_BASE[11:0]};
    else if (in_rng(a, W_MEM_BASE, W_MEM_CNT)) r = {MAP_MEM, a[11:0] - W_MEM_BASE[11:0]};
    return r;
  endfunction : map_word

  wire [13:0] bitMap  = map_bit(mapBitAddr);
  wire [15:0] wordMap = map_word(mapWordAddr);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      frameIdHit  <= 1'b0;
      mapBitKind  <= MAP_NONE;
      mapBitIdx   <= 10'h000;
      mapWordKind <= MAP_NONE;
      mapWordIdx  <= 12'h000;
    end else begin
      frameIdHit  <= frameId == deviceId;
      mapBitKind  <= spbr_map_t'(bitMap[13:10]);
      mapBitIdx   <= bitMap[9:0];
      mapWordKind <= spbr_map_t'(wordMap[15:12]);
      mapWordIdx  <= wordMap[11:0];
    end
  end

endmodule : spbr_top

//--- verification/spbr_top_props.sv
// Port relations checked on the serial port block
`timescale 1ns/1ps
module spbr_top_props (
  input wire logic ref_clk, resetn, charRdReq, charRdReady, charRdValid,
  input wire logic txPin, rs485DriverEn, rs485RecvEnN, frameIdHit,
  input wire logic cfgTimeoutWe, protoLockReq,
  input wire logic [8:0] charRdData, rxCount,
  input wire logic [7:0] frameId, deviceId, cfgTimeoutData, lineTimeout,
  input wire spbr_pkg::spbr_mode_t protoLockMode, protoMode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_char_answer:
    assert property (charRdReq && charRdReady |=> charRdValid)
    else $error("no char answer");
  chk_empty_char:
    assert property (charRdReq && charRdReady && rxCount == 9'h000
      |=> charRdData == 9'h1ff) else $error("empty read not -1");
  chk_count_cap:
    assert property (rxCount <= 9'h100) else $error("rx count too big");
  chk_recv_dir:
    assert property (rs485RecvEnN == rs485DriverEn)
    else $error("receiver not opposite driver");
  chk_line_idle:
    assert property (!rs485DriverEn |-> txPin) else $error("tx low, off");
  chk_start_drive:
    assert property ($fell(txPin) |-> rs485DriverEn)
    else $error("start bit undriven");
  chk_id_match:
    assert property ($past(resetn) |-> frameIdHit == $past(frameId == deviceId))
    else $error("id compare wrong");
  chk_tmo_keep:
    assert property (!cfgTimeoutWe |=> $stable(lineTimeout))
    else $error("timeout changed");
  chk_mode_lock:
    assert property (protoLockReq |=> protoMode == $past(protoLockMode))
    else $error("lock mode wrong");
endmodule : spbr_top_props
bind spbr_top spbr_top_props u_props (.*);

//--- verification/spbr_remote.sv
// Remote serial station on the far side of the RS485 line
`timescale 1ns/1ps
module spbr_remote (
  input  wire logic ref_clk,
  output logic      rxPin,
  input  wire logic txPin
);
  import spbr_pkg::*;
  initial rxPin = 1'b1;
  task automatic send(input logic [7:0] b);
    for (int k = 0; k < 10; k++) begin
      rxPin = k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[k-1];
      repeat (BAUD_DIV) @(negedge ref_clk);
    end
  endtask : send
  task automatic get(output logic [7:0] b);
    int i;
    for (i = 0; i < 9000 && txPin !== 1'b0; i++) @(negedge ref_clk);
    if (i == 9000) testbench.timeOut();
    repeat (BAUD_DIV / 2) @(negedge ref_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BAUD_DIV) @(negedge ref_clk);
      b[k] = txPin;
    end
  endtask : get
endmodule : spbr_remote

//--- verification/testbench.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module testbench;
  import spbr_pkg::*;
  logic ref_clk = 0, resetn = 0, rxPin, txPin, rs485DriverEn, rs485RecvEnN;
  logic charRdReq = 0, charRdReady, charRdValid, lineRdReq = 0, lineRdReady;
  logic lineByteValid, lineRdDone, cfgTimeoutWe = 0, txWrValid = 0;
  logic txWrReady, sendByteReq = 0, sendByteReady, qryReq = 0, qryReady;
  logic qryDone, qryGotReply, protoCmdSeen = 0, protoLockReq = 0, frameIdHit;
  logic [8:0] charRdData, lineRdLen, rxCount, txCount;
  logic [7:0] lineByteData, lineTimeout, txWrData = 0, sendByteData = 0;
  logic [7:0] cfgTimeoutData = 0, deviceId = 0, frameId = 0, got;
  logic [15:0] mapBitAddr = 0, mapWordAddr = 0;
  logic [9:0] mapBitIdx;
  logic [11:0] mapWordIdx;
  spbr_mode_t protoLockMode = MODE_AUTO, protoMode;
  spbr_map_t mapBitKind, mapWordKind;
  int errTotal = 0, samplesChecked = 0, cyc;
  always #50 ref_clk = ~ref_clk;
  spbr_top #(.TICK_CYC(20), .QRY_CYC(200), .AUTO_CYC(50)) DUT (.*);
  spbr_remote far (.ref_clk(ref_clk), .rxPin(rxPin), .txPin(txPin));
  task automatic chk(input logic [15:0] g, e);
    samplesChecked++;
    if (g !== e) begin
      $display("ERROR at %0t got %h exp %h", $time, g, e);
      errTotal++;
    end
  endtask : chk
  task automatic finalReport;
    $display("checks %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finalReport
  task automatic timeOut;
    errTotal++;
    finalReport();
  endtask : timeOut
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
    tick(1);
  endtask : pulse
  task automatic lineRd;
    lineRdReq = 1;
    tick(1);
    lineRdReq = 0;
    for (cyc = 0; cyc < 900 && lineRdDone !== 1'b1; cyc++) begin
      if (lineByteValid === 1'b1) got = lineByteData;
      tick(1);
    end
    if (cyc == 900) timeOut();
    tick(1);
  endtask : lineRd
  task automatic tRead;
    pulse(charRdReq);
    chk(charRdData, 16'h01ff);
    far.send(8'h48);
    far.send(8'h0d);
    pulse(protoCmdSeen);
    chk(rxCount, 16'h0002);
    lineRd();
    chk({lineRdLen, got}, 16'h0148);
    far.send(8'h51);
    lineRd();
    chk({lineRdLen, rxCount}, 16'h0001);
    pulse(charRdReq);
    chk({charRdData, rxCount[6:0]}, 16'h2880);
    $display("read test ends");
  endtask : tRead
  task automatic tBlock;
    cfgTimeoutData = 8'h02;
    pulse(cfgTimeoutWe);
    chk(lineTimeout, 16'h0002);
    lineRd();
    chk(cyc >= 40 && lineRdLen == 0, 1);
    cfgTimeoutData = 8'h00;
    pulse(cfgTimeoutWe);
    lineRd();
    chk(cyc < 8, 1);
    $display("block test ends");
  endtask : tBlock
  task automatic tSend;
    txWrData = 8'h5a;
    pulse(txWrValid);
    far.get(got);
    chk(got, 16'h005a);
    tick(400);
    chk({rs485DriverEn, rxCount}, 16'h0000);
    sendByteData = 8'ha5;
    pulse(sendByteReq);
    far.get(got);
    chk(got, 16'h00a5);
    tick(400);
    chk(rs485DriverEn, 16'h0000);
    $display("send test ends");
  endtask : tSend
  task automatic tQuery;
    txWrData = 8'hc3;
    pulse(txWrValid);
    pulse(qryReq);
    repeat (3) begin
      far.get(got);
      chk(got, 16'h00c3);
    end
    for (cyc = 0; cyc < 900 && qryDone !== 1'b1; cyc++) tick(1);
    if (cyc == 900) timeOut();
    chk({qryGotReply, txCount}, 16'h0000);
    $display("query test ends");
  endtask : tQuery
  task automatic tMisc;
    protoLockMode = MODE_NATIVE;
    pulse(protoLockReq);
    chk(protoMode, MODE_NATIVE);
    tick(60);
    chk(protoMode, MODE_AUTO);
    {mapWordAddr, mapBitAddr, deviceId, frameId} = 48'h03e9_0101_2a2a;
    tick(2);
    chk({mapWordKind, mapWordIdx}, 16'ha001);
    chk({mapBitKind, mapBitIdx}, 16'h0801);
    chk(frameIdHit, 16'h0001);
    $display("misc test ends");
  endtask : tMisc
  initial begin
    tick(12);
    resetn = 1;
    tick(3);
    tRead();
    tBlock();
    tSend();
    tQuery();
    tMisc();
    finalReport();
  end
endmodule : testbench
